// >>> hdl/stop_power_ctrl.sv
// Stop-mode power controller: stop selection, clock gating, power control.
// Assumes CPU, sensor and RF event inputs share sys_clk; the temperature trip pin is synchronised.
//
// Overview of operation
// - Enter active debug from run only with debug entry enable set.
// - Debug status/control reached only by serial read-status/write-control.
// - Debug logic clock keeps running in stop when debug enabled.
// - Regulator stays in full regulation at stop when debug enabled.
// - Deep stop request with debug enabled becomes regulated stop.
// - Memory-with-status commands in stop do no access, return stopped.
// - Halt command in regulated stop wakes device into active debug if enabled.
// - Active debug state accepts every debug command.
// - Stop halts peripheral clocks except wake-up timer and LF receiver.
// - Deep stop puts general pins to high impedance, buffers off.
// - Wake from deep stop resets module registers; RAM lost.
// - Parameter bank of 64 bytes retained, never touched by reset.
// - Low oscillator and wake-up unit always active.
// - Mid oscillator in stop only during measurement or RF processing.
// - High oscillator halted in every stop mode.
// - Converter runs in regulated stop, reset after deep stop.
// - Timer clock halted in stop, timer reset after deep stop.
// - Regulator standby except regulated stop, chosen by lowvolt or debug.
// - Temperature restart powered in stop when enabled; trip restarts device.
// - RF chain stays powered after send while keep bit set.
// - Pressure and acceleration cells powered only during measurement.
// - Bandgap enabled whenever measurement interface needs it.
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps

module stop_power_ctrl
  import stop_power_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdData,
  // CPU events
  input wire logic stopExec,
  input wire logic wakeEvent,
  input wire logic goCmd,
  // Debug link, decoded commands
  input wire dbg_req_t dbgReq,
  output dbg_rsp_t dbgRsp,
  // Measurement and RF activity
  input wire logic measureBusy,
  input wire logic pressMeasure,
  input wire logic accelMeasure,
  input wire logic refNeeded,
  input wire logic rfBusy,
  input wire logic rfSendDone,
  input wire logic tempTripPin,
  // General pins
  input wire logic [3:0] gpOut,
  input wire logic [3:0] gpOe,
  input wire logic [3:0] gpPullEn,
  output logic [3:0] gpOutQ,
  output logic [3:0] gpOeQ,
  output logic [3:0] gpPullQ,
  output logic gpInBufEn,
  // Power and clock controls
  output clk_pwr_t clkPwr,
  output analog_pwr_t anaPwr,
  output logic moduleReset,
  output logic restartReq
);

  pwr_state_t state_reg, state_next;
  logic [7:0] ctrl_reg;
  logic debugEnable_reg;
  logic illegalStop_reg;
  logic deepWake_reg;
  logic rfKeep_reg;
  logic [5:0] paramAddr_reg;
  logic [7:0] paramMem [PARAM_BYTES];
  logic tripMeta_reg, tripSync_reg;
  logic inStop;
  logic deepReq;

  assign inStop = (state_reg == ST_DEEP) || (state_reg == ST_REG);
  assign deepReq = ctrl_reg[CTRL_DEEP];

  // Temperature trip pin synchroniser
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tripMeta_reg <= 1'b0;
      tripSync_reg <= 1'b0;
    end
    else
    begin
      tripMeta_reg <= tempTripPin;
      tripSync_reg <= tripMeta_reg;
    end
  end

  // Mode selection
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:
      begin
        if (dbgReq.cmd == DCMD_HALT && debugEnable_reg)
          state_next = ST_DBG;
        else if (stopExec && ctrl_reg[CTRL_STOPEN])
        begin
          if (deepReq && !debugEnable_reg && !ctrl_reg[CTRL_LVDSTOP])
            state_next = ST_DEEP;
          else
            state_next = ST_REG;
        end
      end
      ST_DEEP:
      begin
        if (wakeEvent)
          state_next = ST_RUN;
      end
      ST_REG:
      begin
        if (dbgReq.cmd == DCMD_HALT && debugEnable_reg)
          state_next = ST_DBG;
        else if (wakeEvent)
          state_next = ST_RUN;
      end
      ST_DBG:
      begin
        if (goCmd)
          state_next = ST_RUN;
      end
      default: state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      state_reg <= ST_RUN;
    else if (tripSync_reg && ctrl_reg[CTRL_TEMPEN])
      state_reg <= ST_RUN;
    else
      state_reg <= state_next;
  end

  // Deep wake and stop error flags
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      deepWake_reg <= 1'b0;
      illegalStop_reg <= 1'b0;
    end
    else
    begin
      deepWake_reg <= (state_reg == ST_DEEP) && (state_next == ST_RUN);
      if (stopExec && state_reg == ST_RUN && !ctrl_reg[CTRL_STOPEN])
        illegalStop_reg <= 1'b1;
      else if (regRead && regAddr == OFS_STATUS)
        illegalStop_reg <= 1'b0;
    end
  end

  assign moduleReset = deepWake_reg;
  assign restartReq = tripSync_reg && ctrl_reg[CTRL_TEMPEN];

  // Control register, reset again after deep wake
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ctrl_reg <= CTRL_RESET;
    else if (deepWake_reg)
      ctrl_reg <= CTRL_RESET;
    else if (regWrite && regAddr == OFS_STOP)
      ctrl_reg <= regWrData;
  end

  // Debug control only via serial commands
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      debugEnable_reg <= 1'b0;
    else if (dbgReq.cmd == DCMD_WR_CONTROL)
      debugEnable_reg <= dbgReq.data[7];
  end

  // Debug responses
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      dbgRsp <= '0;
    else
    begin
      dbgRsp <= '0;
      case (dbgReq.cmd)
        DCMD_RD_STATUS:
        begin
          dbgRsp.ack <= 1'b1;
          dbgRsp.data <= {debugEnable_reg, 3'h0, state_reg};
        end
        DCMD_MEM_STAT:
        begin
          dbgRsp.ack <= 1'b1;
          dbgRsp.err <= inStop;
          dbgRsp.data <= inStop ? DBG_STAT_STOPPED : DBG_STAT_OK;
        end
        DCMD_ACTIVE:
        begin
          dbgRsp.ack <= (state_reg == ST_DBG);
          dbgRsp.err <= (state_reg != ST_DBG);
        end
        DCMD_WR_CONTROL, DCMD_HALT: dbgRsp.ack <= 1'b1;
        default: dbgRsp <= '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rfKeep_reg <= 1'b0;
    else if (rfSendDone)
      rfKeep_reg <= ctrl_reg[CTRL_RFKEEP];
    else if (!ctrl_reg[CTRL_RFKEEP])
      rfKeep_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (regWrite && regAddr == OFS_PARAM_DATA)
      paramMem[paramAddr_reg] <= regWrData;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      paramAddr_reg <= 6'h00;
    else if (regWrite && regAddr == OFS_PARAM_ADDR)
      paramAddr_reg <= regWrData[5:0];
  end

  // Register read port
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      regRdData <= UNMAPPED_READ;
    else if (regRead)
    begin
      case (regAddr)
        OFS_STOP: regRdData <= ctrl_reg;
        OFS_STATUS: regRdData <= {2'b00, deepWake_reg, illegalStop_reg, state_reg};
        OFS_PARAM_ADDR: regRdData <= {2'b00, paramAddr_reg};
        OFS_PARAM_DATA: regRdData <= paramMem[paramAddr_reg];
        default: regRdData <= UNMAPPED_READ;
      endcase
    end
    else
      regRdData <= UNMAPPED_READ;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      gpOutQ <= 4'h0;
      gpOeQ <= 4'h0;
      gpPullQ <= 4'h0;
      gpInBufEn <= 1'b0;
    end
    else if (state_reg == ST_DEEP || deepWake_reg)
    begin
      gpOutQ <= 4'h0;
      gpOeQ <= 4'h0;
      gpPullQ <= 4'h0;
      gpInBufEn <= 1'b0;
    end
    else if (!inStop)
    begin
      gpOutQ <= gpOut;
      gpOeQ <= gpOe;
      gpPullQ <= gpPullEn;
      gpInBufEn <= 1'b1;
    end
  end

  // Clock and power controls
  always_comb
  begin
    clkPwr.periphClk = !inStop;
    clkPwr.wakeupClk = 1'b1;
    clkPwr.lfRxClk = 1'b1;
    clkPwr.lowOscOn = 1'b1;
    clkPwr.debugClk = !inStop || debugEnable_reg;
    clkPwr.convClk = (state_reg != ST_DEEP) && !deepWake_reg;
    clkPwr.timerClk = !inStop && !deepWake_reg;
    clkPwr.hfOscOn = !inStop;
    clkPwr.midOscOn = !inStop || measureBusy || rfBusy;
    clkPwr.regFull = (state_reg != ST_DEEP);
    anaPwr.rfChainOn = rfBusy || rfKeep_reg;
    anaPwr.pressCellOn = pressMeasure;
    anaPwr.accelCellOn = accelMeasure;
    anaPwr.bandgapOn = refNeeded;
    anaPwr.tempRestartOn = !inStop || ctrl_reg[CTRL_TEMPEN];
  end

  // Assertions
  // Debug blocks deep stop
  AST_NO_DEEP_DBG: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == ST_RUN && stopExec && debugEnable_reg && ctrl_reg[CTRL_STOPEN]
     && dbgReq.cmd != DCMD_HALT && !restartReq) |=> state_reg == ST_REG)
    else $error("deep stop entered with debug enabled");
  AST_DBG_GATE: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == ST_RUN && !debugEnable_reg) |=> state_reg != ST_DBG)
    else $error("debug entered while disabled");
  AST_MEM_ERR: assert property (@(posedge sys_clk) disable iff (rst)
    (dbgReq.cmd == DCMD_MEM_STAT && inStop) |=> dbgRsp.err && dbgRsp.data == DBG_STAT_STOPPED)
    else $error("memory status command not refused in stop");
  AST_PERIPH_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    inStop |-> !clkPwr.periphClk && clkPwr.wakeupClk && clkPwr.lfRxClk)
    else $error("peripheral clock running in stop");
  AST_DBG_CLK: assert property (@(posedge sys_clk) disable iff (rst)
    (inStop && debugEnable_reg) |-> clkPwr.debugClk && clkPwr.regFull)
    else $error("debug clock stopped in stop");
  AST_PIN_HIZ: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == ST_DEEP) |=> gpOeQ == 4'h0 && gpPullQ == 4'h0 && !gpInBufEn)
    else $error("pins driven in deep stop");
  AST_HFO_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    inStop |-> !clkPwr.hfOscOn && !clkPwr.timerClk)
    else $error("high oscillator running in stop");
  AST_DEEP_WAKE: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == ST_DEEP && wakeEvent && !restartReq) |=> moduleReset ##1 ctrl_reg == CTRL_RESET)
    else $error("no module reset after deep wake");
  AST_MFO: assert property (@(posedge sys_clk) disable iff (rst)
    (inStop && !measureBusy && !rfBusy) |-> !clkPwr.midOscOn)
    else $error("mid oscillator on without demand");

  COV_DEEP: cover property (@(posedge sys_clk) disable iff (rst) state_reg == ST_DEEP);
  COV_REG_DBG: cover property (@(posedge sys_clk) disable iff (rst)
    state_reg == ST_REG ##1 state_reg == ST_DBG);
  COV_MEM_ERR: cover property (@(posedge sys_clk) disable iff (rst) dbgRsp.err);
  COV_RESTART: cover property (@(posedge sys_clk) disable iff (rst) restartReq);

endmodule : stop_power_ctrl

// >>> hdl/stop_power_pkg.sv
// Package for the stop-mode power controller: offsets, reset values, types.
// Assumes one 50 MHz clock domain and an 8-bit register port.
package stop_power_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PARAM_BYTES = 64;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STOP = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_PARAM_ADDR = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_PARAM_DATA = 4'h4;

  // Control register bit positions
  localparam int CTRL_LVDSTOP = 0;
  localparam int CTRL_DEEP = 1;
  localparam int CTRL_TEMPEN = 2;
  localparam int CTRL_RFKEEP = 3;
  localparam int CTRL_STOPEN = 4;

  // Status register bit positions
  localparam int STAT_RUN = 0;
  localparam int STAT_DEEP = 1;
  localparam int STAT_REG = 2;
  localparam int STAT_DBG = 3;
  localparam int STAT_ILLEGAL = 4;
  localparam int STAT_DEEPWAKE = 5;

  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
  localparam logic [7:0] DBG_STAT_STOPPED = 8'h80;
  localparam logic [7:0] DBG_STAT_OK = 8'h00;

  // Debug commands from the serial link decoder
  typedef enum logic [2:0]
  {
    DCMD_NONE = 3'h0,
    DCMD_RD_STATUS = 3'h1,
    DCMD_WR_CONTROL = 3'h2,
    DCMD_HALT = 3'h3,
    DCMD_MEM_STAT = 3'h4,
    DCMD_ACTIVE = 3'h5
  } dbg_cmd_t;

  typedef struct packed
  {
    dbg_cmd_t cmd;
    logic [7:0] data;
  } dbg_req_t;

  typedef struct packed
  {
    logic ack;
    logic err;
    logic [7:0] data;
  } dbg_rsp_t;

  typedef struct packed
  {
    logic periphClk;
    logic wakeupClk;
    logic lfRxClk;
    logic debugClk;
    logic convClk;
    logic timerClk;
    logic hfOscOn;
    logic midOscOn;
    logic lowOscOn;
    logic regFull;
  } clk_pwr_t;

  typedef struct packed
  {
    logic rfChainOn;
    logic pressCellOn;
    logic accelCellOn;
    logic bandgapOn;
    logic tempRestartOn;
  } analog_pwr_t;

  typedef enum logic [3:0]
  {
    ST_RUN = 4'b0001,
    ST_DEEP = 4'b0010,
    ST_REG = 4'b0100,
    ST_DBG = 4'b1000
  } pwr_state_t;

endpackage : stop_power_pkg

// >>> testbench/dbg_host_model.sv
// Background debug host model: sends decoded serial debug commands.
// Assumes the controller answers one cycle after each command.
`timescale 1ns/100ps
module dbg_host_model
  import stop_power_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Debug link
  input wire dbg_rsp_t dbgRsp,
  output dbg_req_t dbgReq
);
  int idleCycles = 0;

  initial dbgReq = '{DCMD_NONE, 8'h5a};

  task automatic send(input dbg_cmd_t c, input logic [7:0] d, output dbg_rsp_t r);
    repeat (idleCycles) @(posedge sys_clk);
    @(posedge sys_clk);
    dbgReq <= '{c, d};
    @(posedge sys_clk);
    dbgReq <= '{DCMD_NONE, ~d};
    #1 r = dbgRsp;
  endtask : send
endmodule : dbg_host_model

// >>> testbench/tb.sv
// Self-checking bench for the stop-mode power controller.
// Assumes the register port, events and debug host share sys_clk.
`timescale 1ns/100ps
module tb;
  import stop_power_pkg::*;
  logic sys_clk, rst, regWrite, regRead, stopExec, wakeEvent, goCmd;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData;
  logic measureBusy, pressMeasure, accelMeasure, refNeeded, rfBusy, rfSendDone, tempTripPin;
  logic [3:0] gpOut, gpOe, gpPullEn, gpOutQ, gpOeQ, gpPullQ;
  logic gpInBufEn, moduleReset, restartReq;
  logic [31:0] r;
  logic [31:0] seed = 32'h0000df80;
  logic [7:0] pv [4];
  dbg_req_t dbgReq;
  dbg_rsp_t dbgRsp, rsp;
  clk_pwr_t clkPwr;
  analog_pwr_t anaPwr;
  int n_fail = 0;
  int n_compared = 0;

  stop_power_ctrl stop_power_ctrl_inst (.sys_clk, .rst, .regAddr, .regWrData, .regWrite,
    .regRead, .regRdData, .stopExec, .wakeEvent, .goCmd, .dbgReq, .dbgRsp, .measureBusy,
    .pressMeasure, .accelMeasure, .refNeeded, .rfBusy, .rfSendDone, .tempTripPin, .gpOut,
    .gpOe, .gpPullEn, .gpOutQ, .gpOeQ, .gpPullQ, .gpInBufEn, .clkPwr, .anaPwr,
    .moduleReset, .restartReq);
  dbg_host_model dbg_host_model_inst (.sys_clk, .dbgRsp, .dbgReq);

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [7:0] stopState(logic deep, logic dbgEn, logic lowV);
    return (deep && !dbgEn && !lowV) ? 8'h02 : 8'h04;
  endfunction : stopState

  // Clock and power levels expected while stopped
  function automatic logic [9:0] stopClk(logic regStop, logic dbgEn, logic mid);
    return {3'b011, dbgEn, regStop, 2'b00, mid, 1'b1, regStop};
  endfunction : stopClk

  task automatic chk(string name, logic [9:0] exp, logic [9:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(string name, logic [3:0] a, logic [7:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    chk(name, {2'b00, e}, {2'b00, regRdData});
  endtask : rd

  task automatic evt(logic [2:0] m);
    @(posedge sys_clk);
    {stopExec, wakeEvent, goCmd} <= m;
    @(posedge sys_clk);
    {stopExec, wakeEvent, goCmd} <= 3'b000;
  endtask : evt

  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    wrap_up();
  end

  initial
  begin
    {regWrite, regRead, stopExec, wakeEvent, goCmd, rfSendDone, tempTripPin} = '0;
    {measureBusy, pressMeasure, accelMeasure, refNeeded, rfBusy} = '0;
    regAddr = '0;
    regWrData = '0;
    {gpOut, gpOe, gpPullEn} = 12'hfff;
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd("run state", OFS_STATUS, 8'h01);
    rd("unmapped", 4'hf, UNMAPPED_READ);
    chk("low osc", 10'h3, {8'h00, clkPwr.lowOscOn, clkPwr.wakeupClk});
    chk("run pins", 10'h1ff, {1'b0, gpOutQ, gpOeQ, gpInBufEn});
    // Deep stop, debug off
    wr(OFS_STOP, 8'h12);
    evt(3'b100);
    settle();
    chk("deep clocks", stopClk(0, 0, 0), clkPwr);
    chk("deep pins", 10'h000, {1'b0, gpOeQ, gpPullQ, gpInBufEn});
    chk("deep out", 10'h000, {6'h00, gpOutQ});
    rd("deep state", OFS_STATUS, stopState(1, 0, 0));
    // Wake pulse stands for the one cycle after leaving deep stop
    evt(3'b010);
    #1;
    chk("module reset", 10'h001, {9'h000, moduleReset});
    chk("wake clocks", 10'h000, {8'h00, clkPwr.convClk, clkPwr.timerClk});
    rd("ctrl after wake", OFS_STOP, CTRL_RESET);
    // Stop without stop enable stays in run
    evt(3'b100);
    rd("illegal stop", OFS_STATUS, 8'h11);
    rd("illegal clear", OFS_STATUS, 8'h01);
    // Deep request with debug enabled
    dbg_host_model_inst.send(DCMD_WR_CONTROL, 8'h80, rsp);
    chk("write ack", 10'h200, rsp);
    dbg_host_model_inst.send(DCMD_RD_STATUS, 8'h00, rsp);
    chk("debug status", {2'b10, 8'h81}, rsp);
    wr(OFS_STOP, 8'h12);
    evt(3'b100);
    settle();
    chk("dbg stop clocks", stopClk(1, 1, 0), clkPwr);
    rd("dbg stop state", OFS_STATUS, stopState(1, 1, 0));
    dbg_host_model_inst.send(DCMD_MEM_STAT, 8'h00, rsp);
    chk("mem status", {2'b11, DBG_STAT_STOPPED}, rsp);
    dbg_host_model_inst.send(DCMD_HALT, 8'h00, rsp);
    rd("halt wake", OFS_STATUS, 8'h08);
    dbg_host_model_inst.send(DCMD_ACTIVE, 8'h00, rsp);
    chk("active cmd", 10'h002, {8'h00, rsp.ack, rsp.err});
    evt(3'b001);
    rd("go", OFS_STATUS, 8'h01);
    dbg_host_model_inst.send(DCMD_ACTIVE, 8'h00, rsp);
    chk("active in run", 10'h001, {8'h00, rsp.ack, rsp.err});
    dbg_host_model_inst.send(DCMD_HALT, 8'h00, rsp);
    rd("halt enabled", OFS_STATUS, 8'h08);
    evt(3'b001);
    // Slow host turns debug entry off
    dbg_host_model_inst.idleCycles = 2;
    dbg_host_model_inst.send(DCMD_WR_CONTROL, 8'h00, rsp);
    dbg_host_model_inst.send(DCMD_HALT, 8'h00, rsp);
    rd("halt disabled", OFS_STATUS, 8'h01);
    // Low-voltage stop with random sensor activity
    wr(OFS_STOP, 8'h13);
    evt(3'b100);
    rd("lowvolt stop", OFS_STATUS, stopState(1, 0, 1));
    for (int i = 0; i < 8; i++)
    begin
      r = xs();
      @(posedge sys_clk);
      {measureBusy, rfBusy, pressMeasure, accelMeasure, refNeeded} <= r[4:0];
      {gpOut, gpOe, gpPullEn} <= r[16:5];
      settle();
      chk("lv clocks", stopClk(1, 0, r[4] | r[3]), clkPwr);
      chk("cells", {7'h00, r[2:0]}, {7'h00, anaPwr[3:1]});
    end
    evt(3'b010);
    // Temperature restart during stop
    wr(OFS_STOP, 8'h14);
    evt(3'b100);
    settle();
    chk("temp powered", 10'h001, {9'h000, anaPwr.tempRestartOn});
    tempTripPin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("restart", 10'h001, {9'h000, restartReq});
    rd("restart run", OFS_STATUS, 8'h01);
    tempTripPin <= 1'b0;
    // RF chain kept after send
    wr(OFS_STOP, 8'h08);
    @(posedge sys_clk);
    {rfBusy, rfSendDone} <= 2'b01;
    @(posedge sys_clk);
    rfSendDone <= 1'b0;
    settle();
    chk("rf keep", 10'h001, {9'h000, anaPwr.rfChainOn});
    // Parameter bank across a reset, last byte included
    for (int i = 0; i < 4; i++)
    begin
      r = xs();
      pv[i] = r[7:0];
      wr(OFS_PARAM_ADDR, 8'(i * 21));
      wr(OFS_PARAM_DATA, pv[i]);
    end
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_PARAM_ADDR, 8'(i * 21));
      rd("param", OFS_PARAM_DATA, pv[i]);
    end
    wrap_up();
  end
endmodule : tb
